//--- rtl/pt_defines.vh
// Constants for the dual 8-bit or single 16-bit timer.
// Assumes inclusion by bare name.
`ifndef PT_DEFINES_VH
`define PT_DEFINES_VH

// ---------------------------------------------------------------
// Register port
// ---------------------------------------------------------------
`define PT_AW          4
`define PT_DW          8
`define PT_A_CTRL      4'h0
`define PT_A_RATIO     4'h1
`define PT_A_RUN       4'h2
`define PT_A_RLD0      4'h3
`define PT_A_RLD1      4'h4
`define PT_A_CNT0      4'h5
`define PT_A_CNT1      4'h6
`define PT_A_IRQ       4'h7

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PT_B_WIDE      0
`define PT_B_EVENT     1
`define PT_B_NOISE     2
`define PT_B_POL       3
`define PT_B_OUT_CHANNEL_SELECT     4
`define PT_B_OUTEN     5
`define PT_B_T0SRC     6
`define PT_B_T1SRC     7
`define PT_B_RUN0      0
`define PT_B_RUN1      1
`define PT_B_PRESET0   4
`define PT_B_PRESET1   5
`define PT_B_FLAG0     0
`define PT_B_FLAG1     1
`define PT_B_MASK0     4
`define PT_B_MASK1     5
`define PT_F_RATIO0    1:0
`define PT_F_RATIO1    3:2

// ---------------------------------------------------------------
// Values
// ---------------------------------------------------------------
`define PT_R_DIV4      2'b01
`define PT_R_DIV32     2'b10
`define PT_R_DIV256    2'b11
`define PT_M_DIV1      8'h00
`define PT_M_DIV4      8'h03
`define PT_M_DIV32     8'h1f
`define PT_M_DIV256    8'hff
`define PT_ZERO8       8'h00
`define PT_ONES8       8'hff
`define PT_ONE8        8'h01
`define PT_ZERO4       4'h0
`define PT_ZERO2       2'b00
`define PT_ONE2        2'b01
`define PT_NR_LAST     2'b01

`endif

//--- rtl/pt_sync.v
// Three-flop synchroniser for an input from another domain.
// Assumes the input changes slowly against clk_sys.
`timescale 1ns/1ps
`default_nettype none

module pt_sync (
    input  wire clk_sys,   // System clock
    input  wire rst,       // Synchronous reset, active high
    input  wire asyncIn,   // Raw pin level
    output reg  level,     // Accepted level
    output reg  rise,      // One-cycle pulse on accepted rise
    output reg  fall       // One-cycle pulse on accepted fall
);

    reg stage1;            // Metastability catcher, read by stage2 only
    reg stage2;            // Second stage
    reg stage3;            // Third stage, compared with stage2

    // -----------------------------------------------------------
    // Chain and acceptance
    // -----------------------------------------------------------
    // A change counts only once stage2 and stage3 agree
    always @(posedge clk_sys) begin
        if (rst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level  <= 1'b0;
            rise   <= 1'b0;
            fall   <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            stage2 <= stage1;
            stage3 <= stage2;
            rise   <= 1'b0;
            fall   <= 1'b0;
            if ((stage2 == stage3) && (stage3 != level)) begin
                level <= stage3;
                rise  <= stage3;
                fall  <= ~stage3;
            end
        end
    end

endmodule // pt_sync

`default_nettype wire

//--- rtl/pt_timer.v
// Dual 8-bit or chained 16-bit down-counter timer.
// Assumes slow/fast oscillator, 2048 Hz and event pin inputs are
// asynchronous levels much slower than clk_sys.
//
// What this block does
// - Source select: 0 slow, 1 fast oscillator
// - Ratio field divides by 256, 32, 4, 1
// - Run bit enables prescaler, counter decrements
// - Underflow sets timer's flag, requests interrupt
// - Mask gates request only, flag always set
// - Output signal toggles once per underflow
// - Channel select: 0 timer 0, 1 timer 1; wide mode forces timer 1
// - Enable drives pin, else pin high
// - Output enable is asynchronous, glitch allowed
// - Timer 1 halved underflows clock serial link
// - Wide mode chains low and high byte
// - Preset bit loads counter from reload
// - Wide mode: timer 0 run controls both
// - Low-byte read latches high byte buffer
// - Underflow reloads counter and keeps counting
// - Event mode bit: 0 timer, 1 pin
// - Event mode ignores timer 0 prescaler
// - Polarity: 0 falling, 1 rising edges
// - Noise rejector accepts at second 2048 Hz fall
// - Writing one clears flags; clear before re-enable
// - Timer 1 never counts event pin
// - Wide underflow sets timer 1 flag
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pt_defines.vh"

module pt_timer (
    input  wire                clk_sys,       // 10 MHz system clock
    input  wire                rst,           // Sync reset, active high
    input  wire [`PT_AW-1:0]   regAddr,       // Register address
    input  wire [`PT_DW-1:0]   regWdata,      // Write data
    input  wire                regWe,         // Write strobe
    input  wire                regRe,         // Read strobe
    output reg  [`PT_DW-1:0]   regRdata,      // Read data, next cycle
    input  wire                slowOscillator,// Slow oscillator clock
    input  wire                fastOscillator,// Fast oscillator clock
    input  wire                clk2048Hz,     // Internal 2048 Hz signal
    input  wire                eventInputPin, // External event input
    output wire                t0IrqReq,      // Timer 0 interrupt request
    output wire                t1IrqReq,      // Timer 1 interrupt request
    output wire                timerOutSignal,// Halved underflows
    output wire                outputPortPin, // Port pin level
    output wire                serialClk      // Clock to serial link
);

    // -----------------------------------------------------------
    // Control state
    // -----------------------------------------------------------
    reg  [`PT_DW-1:0] ctrl;     // Mode, output and source bits
    reg  [3:0]        ratio;    // Two ratio fields
    reg               run0;     // Timer 0 run bit
    reg               run1;     // Timer 1 run bit
    reg  [7:0]        reload0;  // Timer 0 reload bits
    reg  [7:0]        reload1;  // Timer 1 reload bits
    reg               mask0;    // Timer 0 interrupt mask (1 = pass)
    reg               mask1;    // Timer 1 interrupt mask (1 = pass)

    // -----------------------------------------------------------
    // Datapath state
    // -----------------------------------------------------------
    reg  [7:0]        count0;   // Timer 0 down counter, low byte
    reg  [7:0]        count1;   // Timer 1 down counter, high byte
    reg  [7:0]        hiBuffer; // Timer 1 count buffer
    reg  [7:0]        pre0;     // Timer 0 prescaler
    reg  [7:0]        pre1;     // Timer 1 prescaler
    reg               flag0;    // Timer 0 interrupt flag
    reg               flag1;    // Timer 1 interrupt flag
    reg               half0;    // Timer 0 underflows divided by two
    reg               half1;    // Timer 1 underflows divided by two
    reg               nrLevel;  // Filtered event level
    reg               nrPrev;   // Filtered level one cycle ago
    reg  [1:0]        nrCount;  // 2048 Hz falls since level change

    // Synchronised inputs
    wire slowRise;              // Slow oscillator rising edge
    wire fastRise;              // Fast oscillator rising edge
    wire hzFall;                // 2048 Hz falling edge
    wire eventLevel;            // Synchronised event level

    // Short names for control fields
    wire wideMode    = ctrl[`PT_B_WIDE];
    wire eventMode   = ctrl[`PT_B_EVENT];
    wire noiseReject = ctrl[`PT_B_NOISE];
    wire edgePol     = ctrl[`PT_B_POL];
    wire chanSelect  = ctrl[`PT_B_OUT_CHANNEL_SELECT];
    wire outEnable   = ctrl[`PT_B_OUTEN];

    // -----------------------------------------------------------
    // Functions
    // -----------------------------------------------------------
    // Prescaler mask for a two-bit ratio code
    function [7:0] ratioMask;
        input [1:0] code;
        begin
            case (code)
                `PT_R_DIV256: ratioMask = `PT_M_DIV256;
                `PT_R_DIV32:  ratioMask = `PT_M_DIV32;
                `PT_R_DIV4:   ratioMask = `PT_M_DIV4;
                default:      ratioMask = `PT_M_DIV1;
            endcase
        end
    endfunction

    // Prescaler completes one divided period
    function prescTick;
        input [7:0] pre;
        input [1:0] code;
        begin
            prescTick = ((pre & ratioMask(code)) == ratioMask(code));
        end
    endfunction

    // -----------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------
    pt_sync u_syncSlow (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (slowOscillator),
        .level   (),
        .rise    (slowRise),
        .fall    ()
    );

    pt_sync u_syncFast (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (fastOscillator),
        .level   (),
        .rise    (fastRise),
        .fall    ()
    );

    pt_sync u_syncHz (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (clk2048Hz),
        .level   (),
        .rise    (),
        .fall    (hzFall)
    );

    pt_sync u_syncEvent (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn (eventInputPin),
        .level   (eventLevel),
        .rise    (),
        .fall    ()
    );

    // -----------------------------------------------------------
    // Register decode
    // -----------------------------------------------------------
    wire wrCtrl  = regWe && (regAddr == `PT_A_CTRL);
    wire wrRatio = regWe && (regAddr == `PT_A_RATIO);
    wire wrRun   = regWe && (regAddr == `PT_A_RUN);
    wire wrRld0  = regWe && (regAddr == `PT_A_RLD0);
    wire wrRld1  = regWe && (regAddr == `PT_A_RLD1);
    wire wrIrq   = regWe && (regAddr == `PT_A_IRQ);
    wire rdCnt0  = regRe && (regAddr == `PT_A_CNT0);

    // Presets and flag clears are write strobes
    wire preset0 = wrRun && regWdata[`PT_B_PRESET0];
    wire preset1 = wrRun && regWdata[`PT_B_PRESET1];
    wire clear0  = wrIrq && regWdata[`PT_B_FLAG0];
    wire clear1  = wrIrq && regWdata[`PT_B_FLAG1];

    // Software-written control registers
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl    <= `PT_ZERO8;
            ratio   <= `PT_ZERO4;
            run0    <= 1'b0;
            run1    <= 1'b0;
            reload0 <= `PT_ZERO8;
            reload1 <= `PT_ZERO8;
            mask0   <= 1'b0;
            mask1   <= 1'b0;
        end else begin
            if (wrCtrl) begin
                ctrl <= regWdata;
            end
            if (wrRatio) begin
                ratio <= regWdata[3:0];
            end
            if (wrRun) begin
                run0 <= regWdata[`PT_B_RUN0];
                run1 <= regWdata[`PT_B_RUN1];
            end
            if (wrRld0) begin
                reload0 <= regWdata;
            end
            if (wrRld1) begin
                reload1 <= regWdata;
            end
            if (wrIrq) begin
                mask0 <= regWdata[`PT_B_MASK0];
                mask1 <= regWdata[`PT_B_MASK1];
            end
        end
    end

    // -----------------------------------------------------------
    // Prescalers
    // -----------------------------------------------------------
    // Timer 1 obeys its own run bit only when split
    wire run1Eff  = run1 && !wideMode;
    wire src0Rise = ctrl[`PT_B_T0SRC] ? fastRise : slowRise;
    wire src1Rise = ctrl[`PT_B_T1SRC] ? fastRise : slowRise;
    wire pTick0   = run0 && src0Rise
                    && prescTick(pre0, ratio[`PT_F_RATIO0]);
    wire pTick1   = run1Eff && src1Rise
                    && prescTick(pre1, ratio[`PT_F_RATIO1]);

    // A stopped prescaler restarts at zero, so periods start whole
    always @(posedge clk_sys) begin
        if (rst) begin
            pre0 <= `PT_ZERO8;
            pre1 <= `PT_ZERO8;
        end else begin
            if (!run0 || eventMode) begin
                pre0 <= `PT_ZERO8;
            end else if (src0Rise) begin
                pre0 <= pre0 + `PT_ONE8;
            end
            if (!run1Eff) begin
                pre1 <= `PT_ZERO8;
            end else if (src1Rise) begin
                pre1 <= pre1 + `PT_ONE8;
            end
        end
    end

    // -----------------------------------------------------------
    // Event input and noise rejector
    // -----------------------------------------------------------
    // A change must survive two 2048 Hz falls; a return cancels it
    always @(posedge clk_sys) begin
        if (rst) begin
            nrLevel <= 1'b0;
            nrPrev  <= 1'b0;
            nrCount <= `PT_ZERO2;
        end else begin
            nrPrev <= nrLevel;
            if (!noiseReject) begin
                nrLevel <= eventLevel;
                nrCount <= `PT_ZERO2;
            end else if (eventLevel == nrLevel) begin
                nrCount <= `PT_ZERO2;
            end else if (hzFall) begin
                if (nrCount == `PT_NR_LAST) begin
                    nrLevel <= eventLevel;
                    nrCount <= `PT_ZERO2;
                end else begin
                    nrCount <= nrCount + `PT_ONE2;
                end
            end
        end
    end

    // Selected edge of the filtered event level
    wire evEdge = edgePol ? (nrLevel && !nrPrev)
                          : (!nrLevel && nrPrev);

    // Count clocks; timer 1 never sees the event pin
    wire tick0 = run0 && (eventMode ? evEdge : pTick0);
    wire tick1 = pTick1;

    // -----------------------------------------------------------
    // Down counters
    // -----------------------------------------------------------
    wire lowZero  = (count0 == `PT_ZERO8);
    wire highZero = (count1 == `PT_ZERO8);
    wire borrow   = wideMode && tick0 && lowZero;
    wire uf0      = !wideMode && tick0 && lowZero;
    wire ufWide   = borrow && highZero;
    wire uf1      = wideMode ? ufWide
                             : (tick1 && highZero);

    // Presets win over a count clock in the same cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            count0 <= `PT_ZERO8;
            count1 <= `PT_ZERO8;
        end else begin
            if (preset0) begin
                count0 <= reload0;
            end else if (tick0) begin
                if (!lowZero) begin
                    count0 <= count0 - `PT_ONE8;
                end else if (wideMode && !highZero) begin
                    count0 <= `PT_ONES8;
                end else begin
                    count0 <= reload0;
                end
            end
            if (preset1) begin
                count1 <= reload1;
            end else if (borrow || (!wideMode && tick1)) begin
                if (highZero) begin
                    count1 <= reload1;
                end else begin
                    count1 <= count1 - `PT_ONE8;
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Interrupt flags
    // -----------------------------------------------------------
    // Set beats clear so an underflow during a clear write is kept
    always @(posedge clk_sys) begin
        if (rst) begin
            flag0 <= 1'b0;
            flag1 <= 1'b0;
        end else begin
            flag0 <= uf0 || (flag0 && !clear0);
            flag1 <= uf1 || (flag1 && !clear1);
        end
    end

    // The mask only gates the request, never the flag
    assign t0IrqReq = flag0 && mask0;
    assign t1IrqReq = flag1 && mask1;

    // -----------------------------------------------------------
    // Divide-by-two outputs
    // -----------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rst) begin
            half0 <= 1'b0;
            half1 <= 1'b0;
        end else begin
            if (uf0) begin
                half0 <= !half0;
            end
            if (uf1) begin
                half1 <= !half1;
            end
        end
    end

    // Wide mode has only the combined underflow
    assign timerOutSignal = (chanSelect || wideMode) ? half1
                                                     : half0;
    // Plain mux on the enable: a switch may clip half a period
    assign outputPortPin  = outEnable ? timerOutSignal
                                      : 1'b1;
    // Independent of the output enable
    assign serialClk      = half1;

    // -----------------------------------------------------------
    // Read path
    // -----------------------------------------------------------
    // A low-byte read freezes the high byte
    always @(posedge clk_sys) begin
        if (rst) begin
            hiBuffer <= `PT_ZERO8;
        end else if (rdCnt0) begin
            hiBuffer <= count1;
        end
    end

    // Read data stand one cycle, zero otherwise
    always @(posedge clk_sys) begin
        if (rst) begin
            regRdata <= `PT_ZERO8;
        end else if (!regRe) begin
            regRdata <= `PT_ZERO8;
        end else begin
            case (regAddr)
                `PT_A_CTRL:  regRdata <= ctrl;
                `PT_A_RATIO: regRdata <= {4'h0, ratio};
                `PT_A_RUN:   regRdata <= {6'h00, run1, run0};
                `PT_A_RLD0:  regRdata <= reload0;
                `PT_A_RLD1:  regRdata <= reload1;
                `PT_A_CNT0:  regRdata <= count0;
                `PT_A_CNT1:  regRdata <= hiBuffer;
                `PT_A_IRQ:   regRdata <= {2'b00, mask1, mask0,
                                          2'b00, flag1, flag0};
                default:     regRdata <= `PT_ZERO8;
            endcase
        end
    end

endmodule // pt_timer

`default_nettype wire

//--- dv/pt_timer_props.sv
// Checker bound to the timer's top-level ports.
// Assumes one clk_sys domain with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
`include "pt_defines.vh"
// ------------------------------------------------------------
// Port properties
// ------------------------------------------------------------
module pt_timer_props (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [`PT_AW-1:0] regAddr,
    input wire logic [`PT_DW-1:0] regWdata,
    input wire logic              regWe,
    input wire logic              regRe,
    input wire logic [`PT_DW-1:0] regRdata,
    input wire logic              t0IrqReq,
    input wire logic              t1IrqReq,
    input wire logic              timerOutSignal,
    input wire logic              outputPortPin,
    input wire logic              serialClk
);
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [7:0] ctrl;                        // Control shadow
    logic [1:0] run;                         // Run bits shadow
    logic [1:0] mask;                        // Interrupt mask shadow
    wire        runOn = ctrl[0] ? run[0] : run[1]; // Timer 1 gate
    // Shadows latch on the write edge, like the block
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= 8'h00;
            run <= 2'b00;
            mask <= 2'b00;
        end else if (regWe) begin
            if (regAddr == `PT_A_CTRL) ctrl <= regWdata;
            if (regAddr == `PT_A_RUN) run <= regWdata[1:0];
            if (regAddr == `PT_A_IRQ) mask <= regWdata[5:4];
        end
    end
    // Read of an unmapped place
    sequence s_rd_hole;
        regRe && regAddr[3];
    endsequence
    // Timer 0 output toggles with the mux left alone
    sequence s_tog0;
        !ctrl[0] && !ctrl[4] && mask[0] && $stable(ctrl)
            && $changed(timerOutSignal);
    endsequence
    a_pin_driven:
    assert property (ctrl[5] |-> outputPortPin == timerOutSignal)
        else $error("pin not following output");
    a_pin_high:
    assert property (!ctrl[5] |-> outputPortPin)
        else $error("pin not high while disabled");
    a_irq0_gated:
    assert property (t0IrqReq |-> mask[0])
        else $error("timer 0 request while masked");
    a_timer_out_signal_flag0:
    assert property (s_tog0 |-> t0IrqReq)
        else $error("timer 0 toggle without flag");
    a_serial_flag1:
    assert property (mask[1] && $changed(serialClk) |-> t1IrqReq)
        else $error("serial toggle without flag");
    a_serial_run:
    assert property ($changed(serialClk) |-> $past(runOn))
        else $error("serial clock moved while stopped");
    a_rdata_idle:
    assert property (!regRe |=> regRdata == 8'h00)
        else $error("read data outside read slot");
    a_hole_zero:
    assert property (s_rd_hole |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    a_reset_quiet:
    assert property (disable iff (1'b0) rst |=> !t0IrqReq && !t1IrqReq
        && outputPortPin && !serialClk)
        else $error("outputs not idle after reset");
endmodule // pt_timer_props
`default_nettype wire

//--- dv/pt_far_side.sv
// Far side: oscillators, scaled 2048 Hz reference, event source.
// Assumes periods are given in 100 ns clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Clock sources and event pin
// ------------------------------------------------------------
module pt_far_side #(
    parameter int PS  = 16, // Slow oscillator period
    parameter int PF  = 4,  // Fast oscillator period
    parameter int P2K = 40  // Scaled 2048 Hz period
) (
    input  wire logic clk_sys,
    output var logic  slowOscillator,
    output var logic  fastOscillator,
    output var logic  clk2048Hz,
    output var logic  eventInputPin
);
    // Edges sit 25 ns off clk_sys so no sync flop races them
    // All three sources run from time zero, settled before a start
    initial begin
        {slowOscillator, fastOscillator, clk2048Hz} = 3'h0;
        #25;
        fork
            forever #(PS * 50) slowOscillator = ~slowOscillator;
            forever #(PF * 50) fastOscillator = ~fastOscillator;
            forever #(P2K * 50) clk2048Hz = ~clk2048Hz;
        join
    end
    initial eventInputPin = 1'b0;
    // High for w cycles, then w cycles idle low
    task automatic pulse(input int w);
        @(posedge clk_sys);
        eventInputPin <= 1'b1;
        repeat (w) @(posedge clk_sys);
        eventInputPin <= 1'b0;
        repeat (w) @(posedge clk_sys);
    endtask
endmodule // pt_far_side
`default_nettype wire

//--- dv/pt_timer_tb.sv
// Self-checking bench for the programmable timer.
// Assumes the far-side model supplies the oscillator and 2048 Hz clocks and the event pin; clk_sys comes from this bench.
`timescale 1ns/1ps
`default_nettype none
`include "pt_defines.vh"
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module pt_timer_tb;
    localparam int PS = 16, PF = 4; // Source periods, cycles
    localparam int LIMIT = 90000; // Hang ceiling, cycles
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic [`PT_AW-1:0] regAddr;
    logic [`PT_DW-1:0] regWdata;
    logic              regWe = 1'b0;
    logic              regRe = 1'b0;
    wire  [`PT_DW-1:0] regRdata;
    wire slowOscillator, fastOscillator, clk2048Hz, eventInputPin;
    wire t0IrqReq, t1IrqReq, timerOutSignal, outputPortPin, serialClk;
    int cyc = 0;
    int nFail = 0;
    int checked = 0;
    pt_timer pt_timer_inst (.clk_sys, .rst, .regAddr, .regWdata, .regWe,
        .regRe, .regRdata, .slowOscillator, .fastOscillator, .clk2048Hz,
        .eventInputPin, .t0IrqReq, .t1IrqReq, .timerOutSignal,
        .outputPortPin, .serialClk);
    pt_far_side #(.PS(PS), .PF(PF)) pt_far_side_inst (.clk_sys,
        .slowOscillator, .fastOscillator, .clk2048Hz, .eventInputPin);
    initial forever #50 clk_sys = ~clk_sys;
    // Cycle count: timestamp and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            nFail++;
            conclude();
        end
    end
    task automatic conclude();
        if (nFail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWe <= 1'b1;
        @(posedge clk_sys);
        regWe <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regRe <= 1'b1;
        @(posedge clk_sys);
        regRe <= 1'b0;
        #1 d = regRdata;
    endtask
    // Cycles between toggles: output (0) or serial clock (1)
    task automatic measure(input string nm, input bit w, input int exp);
        logic s;
        int k, tA;
        for (int i = 0; i < 3; i++) begin
            s = w ? serialClk : timerOutSignal;
            k = 0;
            while ((w ? serialClk : timerOutSignal) === s && k < 30000) begin
                @(posedge clk_sys);
                #1;
                k++;
            end
            if (i == 1) tA = cyc;
        end
        chk(nm, 16'(cyc - tA), 16'(exp));
    endtask
    task automatic tReset();
        logic [7:0] v;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), v);
            chk("reset read", v, 8'h00);
        end
        chk("reset pin", outputPortPin, 1'b1);
    endtask
    task automatic tRatios();
        int n;
        wr(`PT_A_RLD0, 8'h01);
        wr(`PT_A_RLD1, 8'h01);
        for (int r = 0; r < 4; r++) begin
            n = (r == 0) ? 1 : (r == 1) ? 4 : (r == 2) ? 32 : 256;
            wr(`PT_A_RUN, 8'h30); // Stop and preset both
            wr(`PT_A_RATIO, {4'h0, 2'(r), 2'(r)});
            wr(`PT_A_CTRL, 8'ha0); // Timer 1 fast, pin driven
            wr(`PT_A_RUN, 8'h03);
            measure("t0 period", 0, 2 * n * PS);
            measure("t1 serial", 1, 2 * n * PF);
            wr(`PT_A_CTRL, 8'hb0);
            measure("t1 on out", 0, 2 * n * PF);
        end
    endtask
    task automatic tFlags();
        wr(`PT_A_RUN, 8'h30);
        wr(`PT_A_IRQ, 8'h03); // Clear flags, masks off
        wr(`PT_A_CTRL, 8'h00);
        wr(`PT_A_RATIO, 8'h00);
        wr(`PT_A_RUN, 8'h01);
        measure("t0 masked", 0, 2 * PS);
        wr(`PT_A_IRQ, 8'h30);
        #1;
        chk("flag kept", t0IrqReq, 1'b1);
        wr(`PT_A_RUN, 8'h00);
        wr(`PT_A_IRQ, 8'h31);
        #1;
        chk("flag clear", t0IrqReq, 1'b0);
    endtask
    task automatic tWide();
        logic [7:0] lo, hi, lo2, hi2;
        wr(`PT_A_CTRL, 8'h21);
        wr(`PT_A_RUN, 8'h30);
        wr(`PT_A_RUN, 8'h01); // Run 0 alone drives both bytes
        measure("wide period", 0, 258 * PS);
        wr(`PT_A_RUN, 8'h02);
        rd(`PT_A_CNT0, lo);
        rd(`PT_A_CNT1, hi);
        repeat (40) @(posedge clk_sys);
        rd(`PT_A_CNT0, lo2);
        rd(`PT_A_CNT1, hi2);
        chk("wide held", {hi2, lo2}, {hi, lo});
        chk("wide range", 16'({hi, lo} <= 16'h0101), 16'h0001);
    endtask
    task automatic tEvent();
        logic [7:0] v;
        wr(`PT_A_RUN, 8'h00);
        wr(`PT_A_RLD0, 8'h03);
        wr(`PT_A_RATIO, 8'h03); // Ignored in event mode
        wr(`PT_A_CTRL, 8'h02);
        wr(`PT_A_RUN, 8'h10);
        wr(`PT_A_RUN, 8'h01);
        pt_far_side_inst.pulse(20);
        pt_far_side_inst.pulse(20);
        rd(`PT_A_CNT0, v);
        chk("falls", v, 8'h01);
        wr(`PT_A_CTRL, 8'h0a);
        pt_far_side_inst.pulse(20);
        rd(`PT_A_CNT0, v);
        chk("rise", v, 8'h00);
        wr(`PT_A_CTRL, 8'h0e);
        pt_far_side_inst.pulse(10);
        pt_far_side_inst.pulse(120);
        rd(`PT_A_CNT0, v);
        chk("filtered", v, 8'h03);
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        tReset();
        tRatios();
        tFlags();
        tWide();
        tEvent();
        conclude();
    end
endmodule // pt_timer_tb
bind pt_timer pt_timer_props pt_timer_props_inst (.clk_sys, .rst,
    .regAddr, .regWdata, .regWe, .regRe, .regRdata, .t0IrqReq,
    .t1IrqReq, .timerOutSignal, .outputPortPin, .serialClk);
`default_nettype wire
